/* verilog/smc_standby_ctrl.v */
// Purpose: standby (halt/hold/stop) and reset-source control with an AXI4-Lite slave
// Assumes: all inputs synchronous to aclk; one write and one read in flight at most
// Notes:   event register bits are write-one pulses that model core-side events
`timescale 1ns/1ps
`include "smc_regs.vh"
module smc_standby_ctrl
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // core events and hold link
  input  wire        irq_pending,
  input  wire        hold_req,
  output reg         bus_grant_acknowledge,
  output reg         bus_oe_n,
  // clock gating and pin control
  output reg         cpu_clk_en,
  output reg         periph_clk_en,
  output reg         rtc_clk_en,
  output reg         main_osc_en,
  output reg         low_speed,
  output reg         pins_float,
  output reg         wdog_run,
  output reg         sys_reset
);

  // mode codes, also reported in the status register
  localparam MODE_RUN  = 2'h0;
  localparam MODE_HALT = 2'h1;
  localparam MODE_HOLD = 2'h2;
  localparam MODE_STOP = 2'h3;

  // software-visible state
  reg [7:0] standby_control_r;
  reg [7:0] peripheral_control_r;
  reg       stop_unlock_acceptor_r;
  reg       key1_seen_r;

  // mode machine
  reg [1:0] mode_r;
  reg [1:0] hold_cnt_r;
  reg       soft_rst_r;

  // write half captured until both address and data are in
  reg [7:0] aw_addr_r;
  reg [7:0] wdata_r;
  reg       aw_have_r;
  reg       w_have_r;
  reg       aw_err_r;

  // mapped registers; anything else answers with an error and has no effect
  function reg_ok;
    input [7:0] a;
    begin
      reg_ok = (a == `SMC_ADDR_UNLOCK) || (a == `SMC_ADDR_STBY_CTRL) ||
               (a == `SMC_ADDR_PERIPH_CTRL) || (a == `SMC_ADDR_EVENT) ||
               (a == `SMC_ADDR_STATUS);
    end
  endfunction

  // a write is applied in the cycle both halves are held and no answer waits
  wire       wr_fire   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire       wr_ok     = wr_fire && !aw_err_r;
  wire [7:0] wb        = wdata_r;

  // per-register write strobes
  wire       wr_unlock = wr_ok && (aw_addr_r == `SMC_ADDR_UNLOCK);
  wire       wr_stby   = wr_ok && (aw_addr_r == `SMC_ADDR_STBY_CTRL);
  wire       wr_periph = wr_ok && (aw_addr_r == `SMC_ADDR_PERIPH_CTRL);
  wire       ev_wr     = wr_ok && (aw_addr_r == `SMC_ADDR_EVENT);

  // the pin or the event register wakes halt and stop
  wire       ev_intr   = irq_pending || (ev_wr && wb[`SMC_EV_INTR]);

  // any reset source, pin reset included, clears the mode, control and unlock state; the axi channels reset on the pin only
  wire       any_rst   = !aresetn || soft_rst_r;

  // stop needs the acceptor armed beforehand; without it the write stores a zero
  wire       stop_wr   = wr_stby && wb[`SMC_BIT_STOP];
  wire       stop_go   = stop_wr && stop_unlock_acceptor_r && (mode_r == MODE_RUN);

  // halt loses to stop in a write carrying both bits, so no stale halt bit survives a stop
  wire       halt_go   = wr_stby && wb[`SMC_BIT_HALT] && !stop_go && (mode_r == MODE_RUN);

  // the hold pin only asks for hold while the hold enable bit of peripheral control is set
  wire       hold_want = peripheral_control_r[`SMC_BIT_HOLD_EN] && hold_req;

  // axi write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      wdata_r       <= 8'h00;
      aw_err_r      <= 1'b0;
    end
    else
    begin
      // ready is a one-cycle pulse, so a valid held through it is taken exactly once
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;

      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        aw_err_r  <= !reg_ok(s_axi_awaddr);
      end

      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        // byte lane 0 only; a write without it stores zero
        wdata_r  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end

      // the answer stands until bready, which also holds off the next write
      if (wr_fire)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_err_r ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      // no new address while an answer waits: one read in flight
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;

      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= reg_ok(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `SMC_ADDR_STBY_CTRL:   s_axi_rdata <= {24'h000000, standby_control_r};
          `SMC_ADDR_PERIPH_CTRL: s_axi_rdata <= {24'h000000, peripheral_control_r};
          `SMC_ADDR_STATUS:      s_axi_rdata <= {24'h000000, 4'h0, bus_grant_acknowledge,
                                                 stop_unlock_acceptor_r, mode_r};
          // unlock acceptor and event register read as zero
          default:               s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // reset sources other than the pin, applied for one cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
      soft_rst_r <= 1'b0;
    else
      // watchdog overflow is ignored while the watchdog is stopped,
      // which is the case in hold and stop
      soft_rst_r <= ev_wr && (wb[`SMC_EV_BREAK] || wb[`SMC_EV_TRAP] ||
                              (wb[`SMC_EV_WDOG] && wdog_run));
  end

  // unlock sequence: n5H then nAH on consecutive writes to the acceptor
  always @(posedge aclk)
  begin
    if (any_rst)
    begin
      stop_unlock_acceptor_r <= 1'b0;
      key1_seen_r            <= 1'b0;
    end
    else if (stop_go)
    begin
      stop_unlock_acceptor_r <= 1'b0;
      key1_seen_r            <= 1'b0;
    end
    else if (wr_unlock)
    begin
      key1_seen_r <= (wb[3:0] == `SMC_KEY1_LO);
      if (key1_seen_r && wb[3:0] == `SMC_KEY2_LO)
        stop_unlock_acceptor_r <= 1'b1;
    end
    // a write to any other mapped register breaks a half-done sequence
    else if (wr_ok)
      key1_seen_r <= 1'b0;
  end

  // control registers and mode machine
  always @(posedge aclk)
  begin
    if (any_rst)
    begin
      standby_control_r    <= `SMC_RST_STBY_CTRL;
      peripheral_control_r <= `SMC_RST_PERIPH_CTRL;
      mode_r               <= MODE_RUN;
      hold_cnt_r           <= 2'h0;
    end
    else
    begin
      if (wr_periph)
        peripheral_control_r <= wb;

      // halt is set only from run; a halt write in another mode is ignored
      if (wr_stby)
      begin
        standby_control_r[7:2] <= wb[7:2];
        if (halt_go)
          standby_control_r[`SMC_BIT_HALT] <= 1'b1;
        // stop bit refused without the unlock
        standby_control_r[`SMC_BIT_STOP] <= stop_go;
      end

      case (mode_r)
        MODE_RUN:
        begin
          hold_cnt_r <= 2'h0;
          if (stop_go)
            mode_r <= MODE_STOP;
          else if (halt_go)
            mode_r <= MODE_HALT;
          else if (hold_want)
            mode_r <= MODE_HOLD;
        end
        MODE_HALT:
          if (ev_intr)
          begin
            mode_r <= MODE_RUN;
            standby_control_r[`SMC_BIT_HALT] <= 1'b0;
          end
        MODE_HOLD:
        begin
          if (!hold_req)
          begin
            mode_r     <= MODE_RUN;
            hold_cnt_r <= 2'h0;
          end
          // the grant waits a fixed count so the pins are already released
          else if (hold_cnt_r != `SMC_HOLD_ACK_DLY)
            hold_cnt_r <= hold_cnt_r + 2'h1;
        end
        MODE_STOP:
          if (ev_intr)
          begin
            mode_r <= MODE_RUN;
            standby_control_r[`SMC_BIT_STOP] <= 1'b0;
          end
        default:
          mode_r <= MODE_RUN;
      endcase
    end
  end

  // registered outputs derived from mode and settings
  always @(posedge aclk)
  begin
    if (any_rst)
    begin
      cpu_clk_en            <= 1'b1;
      periph_clk_en         <= 1'b1;
      rtc_clk_en            <= 1'b1;
      main_osc_en           <= 1'b1;
      low_speed             <= 1'b0;
      pins_float            <= 1'b0;
      wdog_run              <= 1'b1;
      bus_oe_n              <= 1'b0;
      bus_grant_acknowledge <= 1'b0;
      sys_reset             <= !aresetn ? 1'b0 : 1'b1;
    end
    else
    begin
      // sys_reset pulses for the internal sources only; the pin reset is seen by all already
      sys_reset     <= 1'b0;

      cpu_clk_en    <= (mode_r == MODE_RUN);
      periph_clk_en <= (mode_r != MODE_STOP);
      rtc_clk_en    <= 1'b1;

      // quick-wake stop when oscs is clear or the main clock drives the cpu
      main_osc_en   <= !(mode_r == MODE_STOP && standby_control_r[`SMC_BIT_OSCS] &&
                         standby_control_r[7:6] == 2'h3);
      low_speed     <= (standby_control_r[7:6] == 2'h3);
      pins_float    <= (mode_r == MODE_STOP) && standby_control_r[`SMC_BIT_FLOAT];
      wdog_run      <= (mode_r != MODE_HOLD) && (mode_r != MODE_STOP);

      // bus pins released for the whole hold, including secondary-function outputs
      bus_oe_n      <= (mode_r == MODE_HOLD);
      bus_grant_acknowledge <= (mode_r == MODE_HOLD) && hold_req &&
                               (hold_cnt_r == `SMC_HOLD_ACK_DLY);
    end
  end

endmodule

/* verilog/smc_regs.vh */
// Purpose: register map and field layout of the standby mode controller
// Assumes: offsets 0x0e,0x0f,0x15 are indices; byte address is four times the index
// Notes:   header of constants only
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
`define SMC_IDX_UNLOCK      8'h0e
`define SMC_IDX_STBY_CTRL   8'h0f
`define SMC_IDX_PERIPH_CTRL 8'h15
`define SMC_IDX_EVENT       8'h20
`define SMC_IDX_STATUS      8'h21
`define SMC_ADDR_UNLOCK      8'h38
`define SMC_ADDR_STBY_CTRL   8'h3c
`define SMC_ADDR_PERIPH_CTRL 8'h54
`define SMC_ADDR_EVENT       8'h80
`define SMC_ADDR_STATUS      8'h84
`define SMC_RST_STBY_CTRL   8'h08
`define SMC_RST_PERIPH_CTRL 8'h8c
`define SMC_BIT_STOP  0
`define SMC_BIT_HALT  1
`define SMC_BIT_FLOAT 2
`define SMC_BIT_OSCS  3
`define SMC_BIT_CLK1  7
`define SMC_BIT_HOLD_EN 5
`define SMC_KEY1_LO 4'h5
`define SMC_KEY2_LO 4'ha
`define SMC_EV_INTR  0
`define SMC_EV_BREAK 1
`define SMC_EV_TRAP  2
`define SMC_EV_WDOG  3
`define SMC_HOLD_ACK_DLY 2'h2
`endif

/* dv/smc_hold_master.sv */
// Purpose: external bus master that asks for the bus over the hold pin
// Assumes: the bench raises want and drops it after the grant
// Notes:   owns_bus is true only while the grant is seen high
`timescale 1ns/1ps
module smc_hold_master
(
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // bench control and hold link
  input  wire want,
  input  wire bus_grant_acknowledge,
  output reg  hold_req,
  output reg  owns_bus
);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_req <= 1'h0;
      owns_bus <= 1'h0;
    end
    else
    begin
      // level request, dropped before any new request
      hold_req <= want;
      // bus is driven only once the grant is back
      owns_bus <= want && bus_grant_acknowledge;
    end
  end
endmodule

/* dv/smc_standby_checker.sv */
// Purpose: port assertions for the standby controller
// Assumes: one clock, sync active-low reset
// Notes:   bus release one cycle after hold entry, grant two cycles after that
`timescale 1ns/1ps
module smc_standby_checker
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // hold link
  input wire hold_req,
  input wire bus_grant_acknowledge,
  input wire bus_oe_n,
  // clock gating and pins
  input wire cpu_clk_en,
  input wire periph_clk_en,
  input wire rtc_clk_en,
  input wire main_osc_en,
  input wire low_speed,
  input wire pins_float,
  input wire wdog_run
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_ack_delay; $rose(bus_oe_n) |-> !bus_grant_acknowledge ##2 bus_grant_acknowledge; endproperty
  a_ack_delay: assert property (p_ack_delay) else $error("grant not two cycles after release");
  property p_hold_cause; $rose(bus_oe_n) |-> $past(hold_req); endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("bus released without request");
  property p_bus_free; bus_grant_acknowledge |-> bus_oe_n && !cpu_clk_en && !wdog_run; endproperty
  a_bus_free: assert property (p_bus_free) else $error("grant while bus or cpu active");
  property p_hold_keep; bus_grant_acknowledge && hold_req |=> bus_grant_acknowledge; endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("grant dropped under request");
  property p_hold_exit; bus_grant_acknowledge && !hold_req |=> !bus_grant_acknowledge; endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("grant kept after request low");
  property p_stop_clk; !periph_clk_en |-> !cpu_clk_en && rtc_clk_en && !wdog_run; endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("stop gating wrong");
  property p_float; pins_float |-> !periph_clk_en; endproperty
  a_float: assert property (p_float) else $error("pins float outside stop");
  property p_osc; !main_osc_en |-> !periph_clk_en && low_speed; endproperty
  a_osc: assert property (p_osc) else $error("oscillator off outside low-speed stop");
endmodule
bind smc_standby_ctrl smc_standby_checker smc_standby_checker_inst (.*);

/* dv/tb_smc_standby_ctrl.sv */
// Purpose: self-checking bench for the standby mode controller
// Assumes: 20 MHz aclk, sync reset held 8 cycles
// Notes:   outs packs gating and pin outputs so one compare covers a whole mode
`timescale 1ns/1ps
module tb_smc_standby_ctrl;
  logic        aclk = 1'h0, aresetn = 1'h0, irq_pending = 1'h0, want = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         hold_req, bus_grant_acknowledge, bus_oe_n, cpu_clk_en, periph_clk_en, rtc_clk_en;
  wire         main_osc_en, low_speed, pins_float, wdog_run, sys_reset;
  wire  [31:0] outs = {24'h0, cpu_clk_en, periph_clk_en, rtc_clk_en, main_osc_en, low_speed,
                       pins_float, wdog_run, bus_oe_n};
  integer      miscompares = 0, checks = 0, rst_pulses = 0;
  logic [1:0]  resp;
  smc_standby_ctrl smc_standby_ctrl_inst (.*);
  smc_hold_master smc_hold_master_inst (.aclk(aclk), .aresetn(aresetn), .want(want),
    .bus_grant_acknowledge(bus_grant_acknowledge), .hold_req(hold_req), .owns_bus());
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (sys_reset === 1'h1) rst_pulses <= rst_pulses + 1;
  task report_and_stop;
  begin
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // a wait that ran out of its bound ends the run
  task bound(input integer n);
  begin
    if (n >= 40)
    begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    integer n;
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n = n + 1)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    bound(n);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    integer n;
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n = n + 1)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    bound(n);
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e, nm);
  end
  endtask
  task pulse_irq;
  begin
    @(posedge aclk);
    irq_pending <= 1'h1;
    @(posedge aclk);
    irq_pending <= 1'h0;
  end
  endtask
  task t_reset;
  begin
    rd_chk(8'h3c, 32'h08, "sbc");
    rd_chk(8'h54, 32'h8c, "ppc");
    rd_chk(8'h38, 32'h00, "acc");
    chk({30'h0, resp}, 32'h0, "rresp");
    rd_chk(8'hfc, 32'h00, "unm");
    chk({30'h0, resp}, 32'h2, "rresp");
    chk(outs, 32'hf2, "outs");
    wr(8'hfc, 8'h00);
    chk({30'h0, resp}, 32'h2, "bresp");
  end
  endtask
  task t_halt;
  begin
    wr(8'h3c, 8'h0a);
    rd_chk(8'h84, 32'h1, "stat");
    chk(outs, 32'h72, "outs");
    pulse_irq;
    rd_chk(8'h3c, 32'h08, "sbc");
    chk(outs, 32'hf2, "outs");
  end
  endtask
  // stop refused without unlock, and an unlock broken by another write
  task t_stop_refused;
  begin
    wr(8'h3c, 8'h09);
    rd_chk(8'h84, 32'h0, "stat");
    chk(outs, 32'hf2, "outs");
    wr(8'h38, 8'h35);
    wr(8'h3c, 8'h08);
    wr(8'h38, 8'h3a);
    rd_chk(8'h84, 32'h0, "stat");
  end
  endtask
  task t_stop(input logic [3:0] k, input logic [7:0] v, input logic [31:0] e, input logic [31:0] r);
  begin
    wr(8'h38, {k, 4'h5});
    wr(8'h38, {k, 4'ha});
    rd_chk(8'h84, 32'h4, "stat");
    wr(8'h3c, v);
    rd_chk(8'h84, 32'h3, "stat");
    chk(outs, e, "outs");
    pulse_irq;
    rd_chk(8'h3c, {24'h0, v & 8'hfe}, "sbc");
    chk(outs, r, "outs");
  end
  endtask
  task t_hold;
  begin
    @(posedge aclk);
    want <= 1'h1;
    rd_chk(8'h84, 32'h0, "stat");
    want <= 1'h0;
    wr(8'h54, 8'hac);
    want <= 1'h1;
    wait_ack(1'h1);
    chk(outs, 32'h71, "outs");
    @(posedge aclk);
    want <= 1'h0;
    wait_ack(1'h0);
    rd_chk(8'h84, 32'h0, "stat");
    chk(outs, 32'hf2, "outs");
  end
  endtask
  task wait_ack(input logic v);
    integer n;
  begin
    for (n = 0; n < 40 && bus_grant_acknowledge !== v; n = n + 1)
      @(posedge aclk);
    bound(n);
  end
  endtask
  // break, opcode trap and watchdog events each reset the block
  task t_soft;
    integer e, p;
  begin
    for (e = 1; e < 4; e = e + 1)
    begin
      wr(8'h3c, 8'h88);
      wr(8'h38, 8'h05);
      wr(8'h38, 8'h0a);
      rd_chk(8'h84, 32'h4, "stat");
      p = rst_pulses;
      wr(8'h80, 8'h01 << e);
      rd_chk(8'h84, 32'h0, "stat");
      rd_chk(8'h3c, 32'h08, "sbc");
      chk(rst_pulses - p, 32'h1, "rst");
    end
  end
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_halt;
    t_stop_refused;
    t_stop(4'h2, 8'h0d, 32'h34, 32'hf2);
    t_stop(4'h9, 8'hc9, 32'h28, 32'hfa);
    t_stop(4'hc, 8'hc1, 32'h38, 32'hfa);
    wr(8'h3c, 8'h08);
    t_hold;
    t_soft;
    report_and_stop;
  end
endmodule
